// *** sim/selective_wake_config_regs_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module selective_wake_config_regs_tb_top;
    import swk_pkg::*;
    localparam logic [7:0] TRIM_P = 8'h5a;
    localparam logic [4:0] OPT_P = 5'h13;
    logic MCLK, NRST, SOFT_RST, SCK, CSN, SDI, SDO, SILENCE_EXPIRED, CAL_VALID;
    logic [1:0] TRIM_EN;
    logic [7:0] CAL_H_IN, CAL_L_IN;
    logic [3:0][7:0] PAYLOAD;
    logic FD_TOL_EN, RX_FILT_BYPASS, ERR_CNT_OFF, WAKE_RX_SEL;
    logic [2:0] FD_FILT_CODE;
    logic [9:0] FD_FILT_NS;
    logic [6:0] OSC_TRIM;
    int n_errors, total_checks;
    logic [6:0] adr [9] = '{ADR_PAY3, ADR_PAY2, ADR_PAY1, ADR_PAY0, ADR_FD, ADR_TRIM, ADR_OPT, ADR_CALH, ADR_CALL};
    logic [7:0] rstv [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, TRIM_P, {3'h0, OPT_P}, 8'h00, 8'h00};
    logic [7:0] pat [4] = '{8'ha5, 8'h3c, 8'h81, 8'h7e};

    // =========================================================
    // design and host
    swk_cfg_regs #(.TRIM_PRESET(TRIM_P), .OPT_PRESET(OPT_P)) dut (.MCLK(MCLK), .NRST(NRST),
        .SOFT_RST(SOFT_RST), .SCK(SCK), .CSN(CSN), .SDI(SDI), .SDO(SDO), .TRIM_EN(TRIM_EN),
        .SILENCE_EXPIRED(SILENCE_EXPIRED), .CAL_VALID(CAL_VALID), .CAL_H_IN(CAL_H_IN), .CAL_L_IN(CAL_L_IN),
        .PAYLOAD(PAYLOAD), .FD_TOL_EN(FD_TOL_EN), .FD_FILT_CODE(FD_FILT_CODE), .FD_FILT_NS(FD_FILT_NS),
        .RX_FILT_BYPASS(RX_FILT_BYPASS), .ERR_CNT_OFF(ERR_CNT_OFF), .OSC_TRIM(OSC_TRIM), .WAKE_RX_SEL(WAKE_RX_SEL));
    swk_spi_host host (.clk(MCLK), .sck(SCK), .csn(CSN), .sdi(SDI), .sdo(SDO));

    // =========================================================
    // helpers
    task automatic stop_test();
        if (n_errors == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : stop_test

    task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] q;
        host.xfer(a, 1'b1, d, 16, q);
    endtask : wr

    // read returns the register before any write of the same frame
    task automatic rdc(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] q;
        host.xfer(a, 1'b0, 8'h00, 16, q);
        chk("read", {2'h0, e}, {2'h0, q});
    endtask : rdc

    // clock at 25 MHz, and a limit so no run hangs
    initial begin
        MCLK = 1'b0;
        forever #20 MCLK = ~MCLK;
    end
    initial begin
        repeat (40000) @(posedge MCLK);
        n_errors++;
        stop_test();
    end

    // =========================================================
    // main sequence
    initial begin
        logic [7:0] q;
        {NRST, SOFT_RST, TRIM_EN, SILENCE_EXPIRED, CAL_VALID, CAL_H_IN, CAL_L_IN} = '0;
        n_errors = 0;
        total_checks = 0;
        repeat (2) @(posedge MCLK);
        #2 NRST = 1'b1;
        for (int i = 0; i < 9; i++) rdc(adr[i], rstv[i]);
        chk("filt_ns", 10'd50, FD_FILT_NS);
        // payload bytes, byte n lives at 0x33 minus n
        for (int i = 0; i < 4; i++) wr(ADR_PAY0 - 7'(i), pat[i]);
        for (int i = 0; i < 4; i++) begin
            chk("payload", {2'h0, pat[i]}, {2'h0, PAYLOAD[i]});
            rdc(ADR_PAY0 - 7'(i), pat[i]);
        end
        // every filter code, with bypass set and reserved bits written as ones
        for (int c = 0; c < 8; c++) begin
            wr(ADR_FD, {4'hf, 3'(c), 1'b1});
            chk("filt_ns", (c == 7) ? 10'd700 : 10'(50 * (c + 1)), FD_FILT_NS);
            chk("filt_code", 10'(c), {7'h0, FD_FILT_CODE});
            rdc(ADR_FD, {4'h3, 3'(c), 1'b1});
        end
        chk("fd_bits", 10'h7, {7'h0, FD_TOL_EN, RX_FILT_BYPASS, ERR_CNT_OFF});
        // bus silence clears the counter disable bit
        @(posedge MCLK) #2 SILENCE_EXPIRED = 1'b1;
        @(posedge MCLK) #2 SILENCE_EXPIRED = 1'b0;
        rdc(ADR_FD, 8'h1f);
        chk("err_off", 10'h0, {9'h0, ERR_CNT_OFF});
        wr(ADR_FD, 8'h20);
        chk("fd_bits", 10'h0, {7'h0, FD_TOL_EN, RX_FILT_BYPASS, ERR_CNT_OFF});
        // trim and receiver select open only with enable 11; presets written back as read
        for (int t = 0; t < 4; t++) begin
            TRIM_EN = 2'(t);
            wr(ADR_TRIM, {TRIM_P[7], 7'h15});
            wr(ADR_OPT, {1'b1, 2'h3, OPT_P});
            chk("trim", (t == 3) ? 10'h15 : {3'h0, TRIM_P[6:0]}, {3'h0, OSC_TRIM});
            chk("rx_sel", 10'(t == 3), {9'h0, WAKE_RX_SEL});
        end
        rdc(ADR_TRIM, {TRIM_P[7], 7'h15});
        rdc(ADR_OPT, {1'b1, 2'h0, OPT_P});
        // calibration results load, writes bounce off
        CAL_H_IN = 8'hc3;
        CAL_L_IN = 8'h3c;
        CAL_VALID = 1'b1;
        @(posedge MCLK) #2 CAL_VALID = 1'b0;
        wr(ADR_CALH, 8'h00);
        wr(ADR_CALL, 8'hff);
        rdc(ADR_CALH, 8'hc3);
        rdc(ADR_CALL, 8'h3c);
        // a frame one bit short is dropped
        host.xfer(ADR_PAY0, 1'b1, 8'h00, 15, q);
        chk("payload", 10'ha5, {2'h0, PAYLOAD[0]});
        // soft reset brings the bank back to reset values
        @(posedge MCLK) #2 SOFT_RST = 1'b1;
        @(posedge MCLK) #2 SOFT_RST = 1'b0;
        @(posedge MCLK) #2;
        chk("payload", 10'h0, {2'h0, PAYLOAD[0]});
        rdc(ADR_PAY3, 8'h00);
        rdc(ADR_CALH, 8'h00);
        stop_test();
    end
endmodule : selective_wake_config_regs_tb_top
`default_nettype wire

// *** sim/swk_spi_host.sv ***
`timescale 1ns/1ns
`default_nettype none
module swk_spi_host (
    // clock
    input wire logic clk,
    // serial pins
    output logic sck,
    output logic csn,
    output logic sdi,
    input wire logic sdo
);
    // =========================================================
    // idle: serial clock stands still low, frame deselected
    initial begin
        sck = 1'b0;
        csn = 1'b1;
        sdi = 1'b0;
    end

    // one frame, lsb first; n below 16 gives a frame the device must drop
    task automatic xfer(input logic [6:0] a, input logic w, input logic [7:0] d, input int n,
                        output logic [7:0] q);
        logic [15:0] f;
        f = {d, w, a};
        q = 8'h00;
        @(posedge clk) #2 csn = 1'b0;
        for (int i = 0; i < n; i++) begin
            @(posedge clk) #2 sdi = f[i];
            @(posedge clk) #2 sck = 1'b1;
            @(posedge clk) #2 if (i > 7) q[i-8] = sdo;
            @(posedge clk) #2 sck = 1'b0;
        end
        // released line flips so a stale level never looks like data
        @(posedge clk) #2 csn = 1'b1;
        sdi = ~sdi;
        repeat (4) @(posedge clk);
        #2;
    endtask : xfer
endmodule : swk_spi_host
`default_nettype wire

// *** src/swk_cfg_regs.sv ***
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - each of the four payload byte registers holds one wake-frame data byte, bit 0 lsb, bit 7 msb.
// - payload bytes clear to zero on power-on or soft reset, and a restart does not reinitialise them.
// - fd control bit 0 enables fd tolerant mode when one.
// - fd control bits 3:1 pick the dominant filter time, 50 ns steps from 50 to 350 ns, code 7 is 700 ns.
// - fd control bit 5 disables the error counter during selective wake only while fd tolerant mode is on.
// - the device clears the error counter disable bit when the bus silence timeout expires.
// - fd control bit 4 bypasses the analog receive filter while the dominant filter stays active.
// - the 7-bit oscillator trim field accepts writes only while trim enable is binary 11.
// - option bit 7 picks the wake receiver, 0 low power and 1 standard, writable only while trim enable is 11.
// - read-only reserved bits, fd control 7:6 and option 6:5, always read as zero.
// - both calibration registers expose an 8-bit read-only result that resets to zero.
// - access is a 16-bit frame of 7-bit address, access bit at bit 7 (0 is read), then a data byte.
module swk_cfg_regs
    import swk_pkg::*;
#(
    parameter logic [7:0] TRIM_PRESET = 8'h40, // arbitrary factory preset
    parameter logic [4:0] OPT_PRESET = 5'h00 // arbitrary factory preset
) (
    // clock and reset
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic SOFT_RST,
    // serial frame pins
    input wire logic SCK,
    input wire logic CSN,
    input wire logic SDI,
    output logic SDO,
    // device status inputs
    input wire logic [1:0] TRIM_EN,
    input wire logic SILENCE_EXPIRED,
    input wire logic CAL_VALID,
    input wire logic [7:0] CAL_H_IN,
    input wire logic [7:0] CAL_L_IN,
    // configuration outputs
    output logic [3:0][7:0] PAYLOAD,
    output logic FD_TOL_EN,
    output logic [2:0] FD_FILT_CODE,
    output logic [9:0] FD_FILT_NS,
    output logic RX_FILT_BYPASS,
    output logic ERR_CNT_OFF,
    output logic [6:0] OSC_TRIM,
    output logic WAKE_RX_SEL
);

    swk_regs_t q_ff, nxt_q;
    swk_frame_t frame;
    logic done;
    logic wr_hit;
    logic [6:0] rd_addr;
    logic [7:0] rdata;
    logic trim_open;

    localparam swk_regs_t REGS_RST = '{payload: '0, fd_en: 1'b0, fd_filt: FILT_RST, byp: 1'b0,
        errdis: 1'b0, trim_rsv: TRIM_PRESET[TRIM_RSV_BIT], trim: TRIM_PRESET[TRIM_MSB:0],
        rxsel: 1'b0, opt_rsv: OPT_PRESET, cal_h: BYTE_RST, cal_l: BYTE_RST,
        filt_ns: FILT_STEP_NS, errcnt_off: 1'b0};

    // =========================================================
    // filter code to time in ns
    function automatic logic [9:0] filt_ns_f(input logic [2:0] code);
        logic [9:0] t;
        t = (code == FILT_LONG_CODE) ? FILT_LONG_NS : 10'(FILT_STEP_NS * ({7'h00, code} + 10'd1));
        return t;
    endfunction : filt_ns_f

    // =========================================================
    // serial frame engine
    swk_spi_frame u_frame (
        .clk(MCLK),
        .nrst(NRST),
        .sck(SCK),
        .csn(CSN),
        .sdi(SDI),
        .sdo(SDO),
        .rdata(rdata),
        .rd_addr(rd_addr),
        .done(done),
        .frame(frame)
    );

    assign trim_open = (TRIM_EN == TRIM_EN_OPEN);
    assign wr_hit = done & frame.wr; // access bit 0 means read only

    // =========================================================
    // read mux; unmapped addresses answer zero
    always_comb begin
        unique case (rd_addr)
            ADR_PAY3: rdata = q_ff.payload[3];
            ADR_PAY2: rdata = q_ff.payload[2];
            ADR_PAY1: rdata = q_ff.payload[1];
            ADR_PAY0: rdata = q_ff.payload[0];
            ADR_FD: rdata = {2'b00, q_ff.errdis, q_ff.byp, q_ff.fd_filt, q_ff.fd_en};
            ADR_TRIM: rdata = {q_ff.trim_rsv, q_ff.trim};
            ADR_OPT: rdata = {q_ff.rxsel, 2'b00, q_ff.opt_rsv};
            ADR_CALH: rdata = q_ff.cal_h;
            ADR_CALL: rdata = q_ff.cal_l;
            default: rdata = BYTE_RST;
        endcase
    end

    // =========================================================
    // next register state
    always_comb begin
        nxt_q = q_ff;
        // hardware clear first so a same-cycle software set wins
        if (SILENCE_EXPIRED) begin
            nxt_q.errdis = 1'b0;
        end
        // calibration results come only from the oscillator logic
        if (CAL_VALID) begin
            nxt_q.cal_h = CAL_H_IN;
            nxt_q.cal_l = CAL_L_IN;
        end
        if (wr_hit) begin
            unique case (frame.addr)
                ADR_PAY3: nxt_q.payload[3] = frame.data;
                ADR_PAY2: nxt_q.payload[2] = frame.data;
                ADR_PAY1: nxt_q.payload[1] = frame.data;
                ADR_PAY0: nxt_q.payload[0] = frame.data;
                ADR_FD: begin
                    nxt_q.fd_en = frame.data[FD_EN_BIT];
                    nxt_q.fd_filt = frame.data[FD_FILT_MSB:FD_FILT_LSB];
                    nxt_q.byp = frame.data[FD_BYP_BIT];
                    nxt_q.errdis = frame.data[FD_ERRDIS_BIT];
                end
                ADR_TRIM: begin
                    // software is trusted to write back the preset
                    nxt_q.trim_rsv = frame.data[TRIM_RSV_BIT];
                    if (trim_open) begin
                        nxt_q.trim = frame.data[TRIM_MSB:0];
                    end
                end
                ADR_OPT: begin
                    nxt_q.opt_rsv = frame.data[OPT_RSV_MSB:0];
                    if (trim_open) begin
                        nxt_q.rxsel = frame.data[OPT_RXSEL_BIT];
                    end
                end
                default: begin
                    // calibration and unmapped writes are dropped
                end
            endcase
        end
        nxt_q.filt_ns = filt_ns_f(nxt_q.fd_filt);
        nxt_q.errcnt_off = nxt_q.errdis & nxt_q.fd_en;
        // soft reset equals power-on; restart never reaches this bank
        if (SOFT_RST) begin
            nxt_q = REGS_RST;
        end
    end

    // =========================================================
    // state register
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            q_ff <= REGS_RST;
        end else begin
            q_ff <= nxt_q;
        end
    end

    // =========================================================
    // outputs
    assign PAYLOAD = q_ff.payload;
    assign FD_TOL_EN = q_ff.fd_en;
    assign FD_FILT_CODE = q_ff.fd_filt;
    assign FD_FILT_NS = q_ff.filt_ns;
    assign RX_FILT_BYPASS = q_ff.byp; // dominant filter unaffected by this bit
    assign ERR_CNT_OFF = q_ff.errcnt_off;
    assign OSC_TRIM = q_ff.trim;
    assign WAKE_RX_SEL = q_ff.rxsel; // software keeps this at one above 1 Mbit/s

    // =========================================================
    // assertions
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!NRST);

    sequence s_pay0_write;
        wr_hit && frame.addr == ADR_PAY0 && !SOFT_RST;
    endsequence

    sequence s_locked_write(logic [6:0] a);
        wr_hit && frame.addr == a && !trim_open && !SOFT_RST;
    endsequence

    a_payload_store: assert property (s_pay0_write |=> PAYLOAD[0] == $past(frame.data))
        else $error("payload byte zero did not take the written data");
    a_soft_clear: assert property (SOFT_RST |=> PAYLOAD == '0 && q_ff.cal_h == BYTE_RST && !FD_TOL_EN)
        else $error("soft reset did not clear the bank");
    a_fd_enable: assert property (wr_hit && frame.addr == ADR_FD && !SOFT_RST |=>
        FD_TOL_EN == $past(frame.data[FD_EN_BIT]))
        else $error("fd tolerant enable not written");
    a_filter_time: assert property (FD_FILT_NS == ((FD_FILT_CODE == FILT_LONG_CODE) ? FILT_LONG_NS :
        10'(FILT_STEP_NS * ({7'h00, FD_FILT_CODE} + 10'd1))))
        else $error("filter time does not match its code");
    a_errcnt_gate: assert property (ERR_CNT_OFF == (q_ff.errdis & FD_TOL_EN))
        else $error("error counter disable not gated by fd enable");
    a_silence_clear: assert property (SILENCE_EXPIRED && !(wr_hit && frame.addr == ADR_FD) |=>
        !q_ff.errdis && !ERR_CNT_OFF)
        else $error("silence timeout did not clear error counter disable");
    a_trim_locked: assert property (s_locked_write(ADR_TRIM) |=> $stable(OSC_TRIM))
        else $error("trim changed while trim enable closed");
    a_rxsel_locked: assert property (s_locked_write(ADR_OPT) |=> $stable(WAKE_RX_SEL))
        else $error("receiver select changed while trim enable closed");
    a_reserved_zero: assert property ((rd_addr == ADR_FD |-> rdata[7:6] == 2'b00) and
        (rd_addr == ADR_OPT |-> rdata[6:5] == 2'b00))
        else $error("reserved bits read nonzero");
    a_cal_readonly: assert property (wr_hit && frame.addr == ADR_CALH && !CAL_VALID && !SOFT_RST |=>
        $stable(q_ff.cal_h))
        else $error("calibration register changed by a write");

endmodule : swk_cfg_regs
`default_nettype wire

// *** src/swk_pkg.sv ***
package swk_pkg;

    // =========================================================
    // register addresses (7-bit frame address)
    localparam logic [6:0] ADR_PAY3 = 7'h30;
    localparam logic [6:0] ADR_PAY2 = 7'h31;
    localparam logic [6:0] ADR_PAY1 = 7'h32;
    localparam logic [6:0] ADR_PAY0 = 7'h33;
    localparam logic [6:0] ADR_FD = 7'h34;
    localparam logic [6:0] ADR_TRIM = 7'h38;
    localparam logic [6:0] ADR_OPT = 7'h39;
    localparam logic [6:0] ADR_CALH = 7'h3a;
    localparam logic [6:0] ADR_CALL = 7'h3b;

    // =========================================================
    // field positions
    localparam int FD_EN_BIT = 0;
    localparam int FD_FILT_LSB = 1;
    localparam int FD_FILT_MSB = 3;
    localparam int FD_BYP_BIT = 4;
    localparam int FD_ERRDIS_BIT = 5;
    localparam int TRIM_RSV_BIT = 7;
    localparam int TRIM_MSB = 6;
    localparam int OPT_RXSEL_BIT = 7;
    localparam int OPT_RSV_MSB = 4;
    localparam logic [1:0] TRIM_EN_OPEN = 2'h3;

    // =========================================================
    // reset values
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [2:0] FILT_RST = 3'h0;

    // =========================================================
    // dominant filter times
    localparam logic [2:0] FILT_LONG_CODE = 3'h7;
    localparam logic [9:0] FILT_STEP_NS = 10'd50;
    localparam logic [9:0] FILT_LONG_NS = 10'd700;

    // =========================================================
    // frame format
    localparam int FRAME_BITS = 16;
    localparam logic [4:0] FRAME_LEN = 5'h10;
    localparam logic [4:0] DATA_START = 5'h08;

    // =========================================================
    // types
    typedef struct packed {
        logic [6:0] addr;
        logic wr;
        logic [7:0] data;
    } swk_frame_t;

    typedef enum logic [1:0] {
        FS_IDLE = 2'b01,
        FS_SHIFT = 2'b10
    } swk_fstate_t;

    typedef struct packed {
        logic [3:0][7:0] payload;
        logic fd_en;
        logic [2:0] fd_filt;
        logic byp;
        logic errdis;
        logic trim_rsv;
        logic [6:0] trim;
        logic rxsel;
        logic [4:0] opt_rsv;
        logic [7:0] cal_h;
        logic [7:0] cal_l;
        logic [9:0] filt_ns;
        logic errcnt_off;
    } swk_regs_t;

endpackage : swk_pkg

// *** src/swk_spi_frame.sv ***
`timescale 1ns/1ns
`default_nettype none
module swk_spi_frame
    import swk_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // serial pins, sampled on clk
    input wire logic sck,
    input wire logic csn,
    input wire logic sdi,
    output logic sdo,
    // register side
    input wire logic [7:0] rdata,
    output logic [6:0] rd_addr,
    output logic done,
    output swk_frame_t frame
);

    typedef struct packed {
        swk_fstate_t st;
        logic [4:0] cnt;
        logic [FRAME_BITS-1:0] shreg;
        logic sck_q;
        logic sdo;
        logic done;
        logic [6:0] radr;
        swk_frame_t frame;
    } swk_fsh_t;

    swk_fsh_t q_ff, nxt_q;
    logic sck_rise, sck_fall;

    // =========================================================
    // shift engine: lsb first, sample on rise, drive on fall
    assign sck_rise = sck & ~q_ff.sck_q;
    assign sck_fall = ~sck & q_ff.sck_q;

    always_comb begin
        nxt_q = q_ff;
        nxt_q.sck_q = sck;
        nxt_q.done = 1'b0;
        unique case (q_ff.st)
            FS_IDLE: begin
                nxt_q.cnt = 5'h00;
                nxt_q.sdo = 1'b0;
                if (!csn) begin
                    nxt_q.st = FS_SHIFT;
                end
            end
            FS_SHIFT: begin
                if (csn) begin
                    // only a frame of exactly sixteen bits is acted on
                    nxt_q.st = FS_IDLE;
                    nxt_q.done = (q_ff.cnt == FRAME_LEN);
                    nxt_q.frame.addr = q_ff.shreg[6:0];
                    nxt_q.frame.wr = q_ff.shreg[7];
                    nxt_q.frame.data = q_ff.shreg[15:8];
                end else begin
                    // counting stops one past sixteen so a long frame is refused too
                    if (sck_rise && q_ff.cnt <= FRAME_LEN) begin
                        nxt_q.shreg = {sdi, q_ff.shreg[FRAME_BITS-1:1]};
                        nxt_q.cnt = q_ff.cnt + 5'h01;
                    end
                    // hold the address once it is complete; the shifter keeps moving under the data byte
                    if (nxt_q.cnt == DATA_START) begin
                        nxt_q.radr = nxt_q.shreg[14:8];
                    end
                    // the data byte answers with the addressed register
                    if (sck_fall) begin
                        nxt_q.sdo = (q_ff.cnt >= DATA_START && q_ff.cnt < FRAME_LEN) ?
                                    rdata[q_ff.cnt[2:0]] : 1'b0;
                    end
                end
            end
        endcase
    end

    // =========================================================
    // state register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q_ff <= '{st: FS_IDLE, cnt: 5'h00, shreg: 16'h0000, sck_q: 1'b0, sdo: 1'b0,
                      done: 1'b0, radr: 7'h00, frame: '0};
        end else begin
            q_ff <= nxt_q;
        end
    end

    // address latched after eight rising edges, stable for the whole data byte
    assign rd_addr = q_ff.radr;
    assign sdo = q_ff.sdo;
    assign done = q_ff.done;
    assign frame = q_ff.frame;

endmodule : swk_spi_frame
`default_nettype wire
